// ===== rtl/fpi_bitrev.v
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// maps documented numbering (bit 0 = msb) onto verilog numbering
module fpi_bitrev
#(
  parameter WIDTH = 32
)
(
  input wire [WIDTH-1:0] i_doc,
  output wire [WIDTH-1:0] o_word
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_rev
      assign o_word[WIDTH-1-g] = i_doc[g];
    end
  endgenerate
endmodule
`default_nettype wire

// ===== rtl/fpi_map.vh
`ifndef FPI_MAP_VH
`define FPI_MAP_VH
// ==========================================
// register offsets (byte addresses from base)
`define FPI_OFF_FEAT_HIGH 12'h404
`define FPI_OFF_FEAT_LOW 12'h408
`define FPI_OFF_OPT_FUNC 12'h40C
`define FPI_OFF_VENDOR_LOC 12'h480
`define FPI_OFF_PIO_LOC 12'h484
`define FPI_OFF_STROBE_LOC 12'h48C
// ==========================================
// field positions, in documented numbering (0 = msb)
`define FPI_BIT_BRIGHTNESS 0
`define FPI_BIT_AUTO_EXPOSURE 1
`define FPI_BIT_SHARPNESS 2
`define FPI_BIT_WHITE_BALANCE 3
`define FPI_BIT_HUE 4
`define FPI_BIT_SATURATION 5
`define FPI_BIT_GAMMA 6
`define FPI_BIT_SHUTTER 7
`define FPI_BIT_GAIN 8
`define FPI_BIT_IRIS 9
`define FPI_BIT_FOCUS 10
`define FPI_BIT_TEMPERATURE 11
`define FPI_BIT_TRIGGER 12
`define FPI_BIT_TRIGGER_DELAY 13
`define FPI_BIT_WHITE_SHADING 14
`define FPI_BIT_FRAME_RATE_PRIO 15
`define FPI_BIT_ZOOM 0
`define FPI_BIT_PAN 1
`define FPI_BIT_TILT 2
`define FPI_BIT_OPTICAL_FILTER 3
`define FPI_BIT_CAPTURE_SIZE 16
`define FPI_BIT_CAPTURE_QUALITY 17
`define FPI_BIT_PARALLEL_IO 1
`define FPI_BIT_SERIAL_IO 2
`define FPI_BIT_STROBE_OUT 3
// ==========================================
// reserved positions, documented numbering (index = bit number)
`define FPI_RSVD_HIGH 32'hFFFF_0000
`define FPI_RSVD_LOW 32'hFFFC_FFF0
`define FPI_RSVD_OPT 32'hFFFF_FFF1
// ==========================================
// reset value of the read data port
`define FPI_RST_RDATA 32'h0000_0000
`endif

// ===== rtl/fpi_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "fpi_map.vh"
// Overview of operation
// RULE_01 - capability bit one means feature exists
// RULE_02 - values follow current video format and mode; here no format or mode changes any bit
// RULE_03 - brightness, shutter, gain, trigger read one
// RULE_04 - white balance one on colour only
// RULE_05 - other high feature bits read zero
// RULE_06 - trigger delay and white shading zero
// RULE_07 - frame rate priority zero, rest reserved
// RULE_08 - zoom, pan, tilt, filter zero
// RULE_09 - capture size and quality zero
// RULE_10 - parallel io and strobe one, serial zero
// RULE_11 - vendor locator returns quadlet offset
// RULE_12 - parallel io locator returns quadlet offset
// RULE_13 - strobe locator returns quadlet offset
// RULE_14 - all words read only, writes ignored; here a write in the same cycle drops the read
// RULE_15 - documented bit zero is the msb
// RULE_16 - host multiplies locator by four
module fpi_regs
#(
  parameter ADDR_W = 12,
  parameter [31:0] VENDOR_LOC = 32'h0000_0100,
  parameter [31:0] PIO_LOC = 32'h0000_0200,
  parameter [31:0] STROBE_LOC = 32'h0000_0300
)
(
  input wire i_clock,
  input wire i_rst,
  input wire i_colour,
  input wire [2:0] i_video_format,
  input wire [2:0] i_video_mode,
  input wire i_rd,
  input wire i_wr,
  input wire [ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  output reg [31:0] o_rdata,
  output reg o_rvalid,
  output reg o_hit
);
  // ==========================================
  // field values, shared by both variants except white balance
  localparam HAS_BRIGHTNESS = 1'b1;
  localparam HAS_AUTO_EXPOSURE = 1'b0;
  localparam HAS_SHARPNESS = 1'b0;
  localparam HAS_HUE = 1'b0;
  localparam HAS_SATURATION = 1'b0;
  localparam HAS_GAMMA = 1'b0;
  localparam HAS_SHUTTER = 1'b1;
  localparam HAS_GAIN = 1'b1;
  localparam HAS_IRIS = 1'b0;
  localparam HAS_FOCUS = 1'b0;
  localparam HAS_TEMPERATURE = 1'b0;
  localparam HAS_TRIGGER = 1'b1;
  localparam HAS_TRIGGER_DELAY = 1'b0;
  localparam HAS_WHITE_SHADING = 1'b0;
  localparam HAS_FRAME_RATE_PRIO = 1'b0;
  localparam HAS_ZOOM = 1'b0;
  localparam HAS_PAN = 1'b0;
  localparam HAS_TILT = 1'b0;
  localparam HAS_OPTICAL_FILTER = 1'b0;
  localparam HAS_CAPTURE_SIZE = 1'b0;
  localparam HAS_CAPTURE_QUALITY = 1'b0;
  localparam HAS_PARALLEL_IO = 1'b1;
  localparam HAS_SERIAL_IO = 1'b0;
  localparam HAS_STROBE_OUT = 1'b1;

  // ==========================================
  // reserved positions and word count
  localparam [31:0] RSVD_HIGH = `FPI_RSVD_HIGH;
  localparam [31:0] RSVD_LOW = `FPI_RSVD_LOW;
  localparam [31:0] RSVD_OPT = `FPI_RSVD_OPT;
  localparam NUM_WORDS = 6;

  // ==========================================
  // per-format keep masks; limitation: no format drops a feature yet
  localparam [31:0] KEEP_FMT0 = 32'hFFFF_FFFF;
  localparam [31:0] KEEP_FMT1 = 32'hFFFF_FFFF;
  localparam [31:0] KEEP_FMT2 = 32'hFFFF_FFFF;
  localparam [31:0] KEEP_FMT3 = 32'hFFFF_FFFF;
  localparam [31:0] KEEP_FMT4 = 32'hFFFF_FFFF;
  localparam [31:0] KEEP_FMT5 = 32'hFFFF_FFFF;
  localparam [31:0] KEEP_FMT6 = 32'hFFFF_FFFF;
  localparam [31:0] KEEP_FMT7 = 32'hFFFF_FFFF;

  // ==========================================
  // presence words in documented numbering
  reg [31:0] feat_high_doc;
  reg [31:0] feat_low_doc;
  reg [31:0] opt_func_doc;
  reg [31:0] keep_high;
  reg [31:0] keep_low;
  reg [31:0] keep_opt;
  wire [31:0] feat_high_clr;
  wire [31:0] feat_low_clr;
  wire [31:0] opt_func_clr;
  wire [31:0] feat_high;
  wire [31:0] feat_low;
  wire [31:0] opt_func;
  wire [NUM_WORDS*ADDR_W-1:0] word_addr;
  wire [NUM_WORDS*32-1:0] word_data;
  wire [NUM_WORDS-1:0] word_sel;
  wire [32*(NUM_WORDS+1)-1:0] mux_chain;
  wire [NUM_WORDS:0] hit_chain;
  wire rd_take;
  wire [31:0] next_rdata;
  wire next_hit;
  wire unused_wdata;
  wire unused_mode;

  // ==========================================
  // presence table
  // strap is read live, so a variant swap shows on the next read
  always @*
  begin
    feat_high_doc = 32'h0000_0000; // see RULE_07
    feat_high_doc[`FPI_BIT_BRIGHTNESS] = HAS_BRIGHTNESS; // see RULE_03 see RULE_01
    feat_high_doc[`FPI_BIT_AUTO_EXPOSURE] = HAS_AUTO_EXPOSURE; // see RULE_05
    feat_high_doc[`FPI_BIT_SHARPNESS] = HAS_SHARPNESS; // see RULE_05
    feat_high_doc[`FPI_BIT_WHITE_BALANCE] = i_colour; // see RULE_04
    feat_high_doc[`FPI_BIT_HUE] = HAS_HUE; // see RULE_05
    feat_high_doc[`FPI_BIT_SATURATION] = HAS_SATURATION; // see RULE_05
    feat_high_doc[`FPI_BIT_GAMMA] = HAS_GAMMA; // see RULE_05
    feat_high_doc[`FPI_BIT_SHUTTER] = HAS_SHUTTER; // see RULE_03
    feat_high_doc[`FPI_BIT_GAIN] = HAS_GAIN; // see RULE_03
    feat_high_doc[`FPI_BIT_IRIS] = HAS_IRIS; // see RULE_05
    feat_high_doc[`FPI_BIT_FOCUS] = HAS_FOCUS; // see RULE_05
    feat_high_doc[`FPI_BIT_TEMPERATURE] = HAS_TEMPERATURE; // see RULE_05
    feat_high_doc[`FPI_BIT_TRIGGER] = HAS_TRIGGER; // see RULE_03
    feat_high_doc[`FPI_BIT_TRIGGER_DELAY] = HAS_TRIGGER_DELAY; // see RULE_06
    feat_high_doc[`FPI_BIT_WHITE_SHADING] = HAS_WHITE_SHADING; // see RULE_06
    feat_high_doc[`FPI_BIT_FRAME_RATE_PRIO] = HAS_FRAME_RATE_PRIO; // see RULE_07
    feat_low_doc = 32'h0000_0000; // see RULE_08 see RULE_09
    feat_low_doc[`FPI_BIT_ZOOM] = HAS_ZOOM; // see RULE_08
    feat_low_doc[`FPI_BIT_PAN] = HAS_PAN; // see RULE_08
    feat_low_doc[`FPI_BIT_TILT] = HAS_TILT; // see RULE_08
    feat_low_doc[`FPI_BIT_OPTICAL_FILTER] = HAS_OPTICAL_FILTER; // see RULE_08
    feat_low_doc[`FPI_BIT_CAPTURE_SIZE] = HAS_CAPTURE_SIZE; // see RULE_09
    feat_low_doc[`FPI_BIT_CAPTURE_QUALITY] = HAS_CAPTURE_QUALITY; // see RULE_09
    opt_func_doc = 32'h0000_0000; // see RULE_10
    opt_func_doc[`FPI_BIT_PARALLEL_IO] = HAS_PARALLEL_IO; // see RULE_10
    opt_func_doc[`FPI_BIT_SERIAL_IO] = HAS_SERIAL_IO; // see RULE_10
    opt_func_doc[`FPI_BIT_STROBE_OUT] = HAS_STROBE_OUT; // see RULE_10
  end

  // ==========================================
  // format hook; one table per format masks the same bit position in all three words
  always @*
  begin
    case (i_video_format) // see RULE_02
      3'h0:
      begin
        keep_high = KEEP_FMT0;
        keep_low = KEEP_FMT0;
        keep_opt = KEEP_FMT0;
      end
      3'h1:
      begin
        keep_high = KEEP_FMT1;
        keep_low = KEEP_FMT1;
        keep_opt = KEEP_FMT1;
      end
      3'h2:
      begin
        keep_high = KEEP_FMT2;
        keep_low = KEEP_FMT2;
        keep_opt = KEEP_FMT2;
      end
      3'h3:
      begin
        keep_high = KEEP_FMT3;
        keep_low = KEEP_FMT3;
        keep_opt = KEEP_FMT3;
      end
      3'h4:
      begin
        keep_high = KEEP_FMT4;
        keep_low = KEEP_FMT4;
        keep_opt = KEEP_FMT4;
      end
      3'h5:
      begin
        keep_high = KEEP_FMT5;
        keep_low = KEEP_FMT5;
        keep_opt = KEEP_FMT5;
      end
      3'h6:
      begin
        keep_high = KEEP_FMT6;
        keep_low = KEEP_FMT6;
        keep_opt = KEEP_FMT6;
      end
      3'h7:
      begin
        keep_high = KEEP_FMT7;
        keep_low = KEEP_FMT7;
        keep_opt = KEEP_FMT7;
      end
      default:
      begin
        keep_high = KEEP_FMT0;
        keep_low = KEEP_FMT0;
        keep_opt = KEEP_FMT0;
      end
    endcase
  end

  // mode changes no bit yet, kept as a port for later tables
  assign unused_mode = ^i_video_mode; // see RULE_02

  // ==========================================
  // reserved positions forced to zero whatever the table says
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_rsvd
      assign feat_high_clr[g] = feat_high_doc[g] & keep_high[g] & ~RSVD_HIGH[g]; // see RULE_07
      assign feat_low_clr[g] = feat_low_doc[g] & keep_low[g] & ~RSVD_LOW[g]; // see RULE_09
      assign opt_func_clr[g] = opt_func_doc[g] & keep_opt[g] & ~RSVD_OPT[g]; // see RULE_10
    end
  endgenerate

  // ==========================================
  // documented numbering onto bus numbering
  fpi_bitrev #(.WIDTH(32)) u_rev_high
  (
    .i_doc(feat_high_clr),
    .o_word(feat_high) // see RULE_15
  );

  fpi_bitrev #(.WIDTH(32)) u_rev_low
  (
    .i_doc(feat_low_clr),
    .o_word(feat_low) // see RULE_15
  );

  fpi_bitrev #(.WIDTH(32)) u_rev_opt
  (
    .i_doc(opt_func_clr),
    .o_word(opt_func) // see RULE_15
  );

  // ==========================================
  // word table
  assign word_addr[0*ADDR_W +: ADDR_W] = `FPI_OFF_FEAT_HIGH;
  assign word_addr[1*ADDR_W +: ADDR_W] = `FPI_OFF_FEAT_LOW;
  assign word_addr[2*ADDR_W +: ADDR_W] = `FPI_OFF_OPT_FUNC;
  assign word_addr[3*ADDR_W +: ADDR_W] = `FPI_OFF_VENDOR_LOC;
  assign word_addr[4*ADDR_W +: ADDR_W] = `FPI_OFF_PIO_LOC;
  assign word_addr[5*ADDR_W +: ADDR_W] = `FPI_OFF_STROBE_LOC;
  assign word_data[0*32 +: 32] = feat_high;
  assign word_data[1*32 +: 32] = feat_low;
  assign word_data[2*32 +: 32] = opt_func;
  assign word_data[3*32 +: 32] = VENDOR_LOC; // see RULE_11
  assign word_data[4*32 +: 32] = PIO_LOC; // see RULE_12
  assign word_data[5*32 +: 32] = STROBE_LOC; // see RULE_13

  // ==========================================
  // and-or read mux; unmapped reads give zero with o_hit low
  assign mux_chain[31:0] = 32'h0000_0000;
  assign hit_chain[0] = 1'b0;
  generate
    for (g = 0; g < NUM_WORDS; g = g + 1)
    begin : g_word
      assign word_sel[g] = (i_addr == word_addr[g*ADDR_W +: ADDR_W]);
      assign mux_chain[(g+1)*32 +: 32] = mux_chain[g*32 +: 32]
        | ({32{word_sel[g]}} & word_data[g*32 +: 32]);
      assign hit_chain[g+1] = hit_chain[g] | word_sel[g];
    end
  endgenerate
  assign next_rdata = mux_chain[NUM_WORDS*32 +: 32];
  assign next_hit = hit_chain[NUM_WORDS];

  // ==========================================
  // read register; writes are never decoded, so nothing changes on them
  // a read that collides with a write is dropped rather than guessed at
  assign rd_take = i_rd & ~i_wr; // see RULE_14
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_rdata <= `FPI_RST_RDATA;
      o_rvalid <= 1'b0;
      o_hit <= 1'b0;
    end
    else
    begin
      o_rvalid <= rd_take;
      o_hit <= rd_take & next_hit;
      if (rd_take)
      begin
        o_rdata <= next_rdata;
      end
    end
  end

  // i_wdata is accepted and dropped on purpose
  assign unused_wdata = ^i_wdata; // see RULE_14
endmodule
`default_nettype wire

// ===== tb/fpi_host.sv
`timescale 1ns/1ns
`default_nettype none
module fpi_host (
  input wire logic i_clock,
  output logic o_rd = 1'b0,
  output logic o_wr = 1'b0,
  output logic [11:0] o_addr = 12'h0,
  output logic [31:0] o_wdata = 32'h0);
  task acc(input logic w, input logic [11:0] a);
    @(negedge i_clock);
    {o_rd, o_wr, o_addr, o_wdata} = {!w, w, a, 32'hFFFFFFFF};
    @(negedge i_clock);
    {o_rd, o_wr, o_addr, o_wdata} = {2'h0, ~a, 32'h0};
  endtask
endmodule
`default_nettype wire

// ===== tb/fpi_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fpi_regs_monitor #(parameter [31:0] VENDOR_LOC = 32'h100, PIO_LOC = 32'h200,
  STROBE_LOC = 32'h300) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_colour,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire [11:0] a = i_rd && !i_wr ? i_addr : 12'h0;
  wire [31:0] d = o_rdata;
  AST_HI: assert property (a == 12'h404 |=>
    d == {3'h4, $past(i_colour), 28'h1880000}) else $error("hi");
  AST_LO: assert property (a == 12'h408 |=> d == 32'h0) else $error("lo");
  AST_OP: assert property (a == 12'h40C |=> d == 32'h50000000) else $error("op");
  AST_VL: assert property (a == 12'h480 |=> d == VENDOR_LOC) else $error("vl");
  AST_PL: assert property (a == 12'h484 |=> d == PIO_LOC) else $error("pl");
  AST_SL: assert property (a == 12'h48C |=> d == STROBE_LOC) else $error("sl");
  AST_WR: assert property (i_wr |=> !o_rvalid) else $error("wr");
  AST_HOLD: assert property (!i_rd |=> $stable(d)) else $error("hold");
endmodule
bind fpi_regs fpi_regs_monitor #(.VENDOR_LOC(VENDOR_LOC), .PIO_LOC(PIO_LOC),
  .STROBE_LOC(STROBE_LOC)) i_mon (.*);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_clock = 1'b0, i_rst = 1'b1, i_colour = 1'b0;
  wire i_rd, i_wr, o_rvalid, o_hit;
  wire [11:0] i_addr;
  wire [31:0] i_wdata, o_rdata;
  // format follows the strap so a variant swap also moves the format
  wire [2:0] i_video_format = {3{i_colour}};
  logic [2:0] i_video_mode = 3'h1;
  wire [33:0] x = {o_rvalid, o_hit, o_rdata};
  int num_errors = 0, check_count = 0;
  logic [43:0] row [7] = '{{12'h404, 32'h81880000}, {12'h408, 32'h0}, {12'h40C, 32'h50000000},
    {12'h480, 32'h100}, {12'h484, 32'h200}, {12'h48C, 32'h300}, {12'h400, 32'h0}};
  always #10 i_clock = ~i_clock;
  fpi_regs i_fpi_regs (.*);
  fpi_host i_fpi_host (.i_clock, .o_rd(i_rd), .o_wr(i_wr), .o_addr(i_addr), .o_wdata(i_wdata));
  task chk(input logic [33:0] e);
    check_count++;
    num_errors += (x !== e);
    if (x !== e)
      $display("Error answer exp %h got %h", e, x);
  endtask
  // host side turns a quadlet locator into a byte offset
  task chk_off(input logic [31:0] e);
    check_count++;
    num_errors += ({o_rdata[29:0], 2'h0} !== e);
    if ({o_rdata[29:0], 2'h0} !== e)
      $display("Error byte_offset exp %h got %h", e, {o_rdata[29:0], 2'h0});
  endtask
  task end_sim;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge i_clock);
    chk(34'h0);
    i_rst = 1'b0;
    foreach (row[i])
    begin
      i_fpi_host.acc(1'b0, row[i][43:32]);
      chk({1'b1, i < 6, row[i][31:0]});
    end
    i_colour = 1'b1;
    i_fpi_host.acc(1'b0, 12'h404);
    chk({2'h3, 32'h91880000});
    i_fpi_host.acc(1'b1, 12'h404);
    chk({2'h0, 32'h91880000});
    i_fpi_host.acc(1'b0, 12'h480);
    chk_off(32'h0000_0400);
    i_video_mode = 3'h5;
    i_fpi_host.acc(1'b0, 12'h404);
    chk({2'h3, 32'h91880000});
    @(negedge i_clock);
    i_rst = 1'b1;
    @(negedge i_clock);
    chk(34'h0);
    i_rst = 1'b0;
    i_fpi_host.acc(1'b0, 12'h40C);
    chk({2'h3, 32'h50000000});
    end_sim;
  end
endmodule
`default_nettype wire
